// File: bench/rcp_host.sv
/*
  host model on the byte port of the register bank.
  assumes the fixed one-cycle read latency of the bank.
*/
`timescale 1ns/1ps
module rcp_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rd_valid,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [6:0] o_addr,
  output logic [7:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 7'h00;
    o_wdata = 8'h00;
  end
  // released lines are inverted so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b1;
    o_addr = a;
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b0;
    o_addr = ~a;
    ok = (i_rd_valid === 1'b1);
    d = i_rdata;
  endtask : rd
  // only divisors of the 1.6 GHz grid are ever sent
  // both bytes go back to back with the strobe held between them
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    if (v != 16'h0000 && (64'd1600000000 % v) == 0) begin
      @(posedge i_clk);
      #1;
      o_wr_en = 1'b1;
      o_addr = a;
      o_wdata = v[15:8];
      @(posedge i_clk);
      #1;
      o_addr = a + 7'h01;
      o_wdata = v[7:0];
      @(posedge i_clk);
      #1;
      o_wr_en = 1'b0;
      o_addr = ~a;
      o_wdata = ~v[7:0];
    end
  endtask : wr16
endmodule : rcp_host

// File: bench/tb_top.sv
/*
  self-checking bench for the reference configuration register bank.
  assumes host model rcp_host drives the byte port.
*/
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [2:0] ref_clk = 3'h0;
  logic wr_en, rd_en, rd_valid;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, win;
  logic [2:0] pre, ref_out;
  logic [15:0] base_hz;
  int failures = 0;
  int tests_run = 0;
  always #50 i_clk = ~i_clk;
  always begin
    repeat (8) @(posedge i_clk);
    #1;
    ref_clk = ~ref_clk;
  end
  rcp_host host_u (.i_clk(i_clk), .i_rdata(rdata), .i_rd_valid(rd_valid), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
  rcp_bank dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .i_ref_clk(ref_clk), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_window_select(win), .o_prescale_en(pre), .o_ref_clk_out(ref_out), .o_input0_base_hz(base_hz));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rchk(input string name, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_u.rd(a, d, ok);
    check(name, {7'h00, ok, d}, {7'h01, exp});
  endtask : rchk
  // 128 cycles hold 8 pin periods, so 4 rising edges when halved
  task automatic ref_chk(input logic [2:0] en);
    int n [3];
    logic [2:0] prev;
    n = '{0, 0, 0};
    // a freshly written enable reaches the output one edge later
    @(posedge i_clk);
    #1;
    prev = ref_out;
    repeat (128) begin
      @(posedge i_clk);
      #1;
      for (int k = 0; k < 3; k++) if (ref_out[k] === 1'b1 && prev[k] === 1'b0) n[k]++;
      prev = ref_out;
    end
    for (int k = 0; k < 3; k++) check("ref edges", 16'(n[k]), en[k] ? 16'd4 : 16'd8);
  endtask : ref_chk
  task automatic complete_run();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    check("base rst", base_hz, 16'h9c40);
    check("win rst", {8'h00, win}, 16'h0000);
    rchk("pre rst", 7'h7d, 8'h00);
    host_u.wr(7'h7d, 8'hfd);
    rchk("pre rd", 7'h7d, 8'h05);
    check("pre en", {13'h0000, pre}, 16'h0005);
    ref_chk(3'h5);
    host_u.wr(7'h7f, 8'h01);
    rchk("base msb", 7'h00, 8'h9c);
    rchk("base lsb", 7'h01, 8'h40);
    host_u.wr(7'h00, 8'h1f);
    check("staged", base_hz, 16'h9c40);
    rchk("active msb", 7'h00, 8'h9c);
    host_u.wr(7'h01, 8'h40);
    check("commit", base_hz, 16'h1f40);
    host_u.wr16(7'h00, 16'h61a8);
    check("wide wr", base_hz, 16'h61a8);
    for (int c = 0; c < 6; c++) begin
      host_u.wr(7'h7f, 8'(c));
      check("win", {8'h00, win}, 16'(c));
      rchk("win rd", 7'h7f, 8'(c));
      rchk("blk msb", 7'h00, (c == 1) ? 8'h61 : 8'h00);
      rchk("blk pre", 7'h7d, (c == 0) ? 8'h05 : 8'h00);
    end
    host_u.wr(7'h7f, 8'h06);
    host_u.wr(7'h01, 8'h00);
    rchk("rsv rd", 7'h01, 8'h00);
    check("rsv base", base_hz, 16'h61a8);
    @(posedge i_clk);
    #1;
    i_reset = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    check("base rst2", base_hz, 16'h9c40);
    check("win rst2", {8'h00, win}, 16'h0000);
    check("pre rst2", {13'h0000, pre}, 16'h0000);
    host_u.wr(7'h7f, 8'h00);
    host_u.wr(7'h7d, 8'h02);
    ref_chk(3'h2);
    complete_run();
  end
endmodule : tb_top

// File: common/rcp_byte_if.sv
/*
  byte write path from the register bank to a staged 16-bit register.
  assumes wr_hi and wr_lo are never high in the same cycle.
*/
`timescale 1ns/1ps
interface rcp_byte_if;
  logic wr_hi;
  logic wr_lo;
  logic [7:0] wdata;
  logic [15:0] value;
  modport bank (output wr_hi, output wr_lo, output wdata, input value);
  modport store (input wr_hi, input wr_lo, input wdata, output value);
endinterface : rcp_byte_if

// File: common/rcp_pkg.sv
/*
  constants shared by the reference configuration register bank:
  byte addresses, field layout, reset values and the window decode.
  assumes an 8-bit host port with a 7-bit offset inside a 128-byte window.
*/
package rcp_pkg;
  localparam int unsigned OFS_W = 7;
  localparam int unsigned FULL_W = 10;
  localparam int unsigned PRESCALE_BITS = 3;
  localparam logic [9:0] PRESCALE_ADDR = 10'h07d;
  localparam logic [9:0] BASE_HI_ADDR = 10'h080;
  localparam logic [9:0] BASE_LO_ADDR = 10'h081;
  localparam logic [6:0] WINDOW_SEL_OFS = 7'h7f;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [7:0] WINDOW_SEL_RST = 8'h00;
  localparam logic [7:0] WINDOW_SEL_MAX = 8'h05;
  localparam logic [15:0] BASE_HZ_RST = 16'h9c40;

  // page code selects the upper address bits; only codes up to 5 are legal
  function automatic logic [9:0] full_addr(input logic [7:0] page, input logic [6:0] ofs);
    return {page[2:0], ofs};
  endfunction : full_addr
endpackage : rcp_pkg

// File: verilog/rcp_bank.sv
/*
  reference configuration register bank: high reference prescale enables,
  register window select and the reference 0 base frequency, plus the
  divide-by-two stage for the three highest reference inputs.
  assumes a host byte port on i_clk and reference clocks from pins, far
  slower than i_clk, since they are sampled rather than clocked on.
*/
// Function
// [RULE_01] three prescale enables in bits two to zero
// [RULE_02] enabled prescale halves its reference clock
// [RULE_03] window select byte chooses reachable 128-byte block
// [RULE_04] codes zero to five map consecutive blocks
// [RULE_05] base frequency in hertz, resets to 40 kHz
// [RULE_06] host programs only divisors of 1600000000
// [RULE_07] upper byte at lower address, big endian
// [RULE_08] host writes low byte last
// [RULE_09] stage upper byte, commit on low byte
`timescale 1ns/1ps
module rcp_bank (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [2:0] i_ref_clk,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  output logic [7:0] o_window_select,
  output logic [2:0] o_prescale_en,
  output logic [2:0] o_ref_clk_out,
  output logic [15:0] o_input0_base_hz
);
  logic [2:0] prescale_reg;
  logic [7:0] window_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rd_valid_reg;
  logic [9:0] cur_addr;
  logic window_ok;
  logic wr_window;
  logic wr_prescale;

  rcp_byte_if base_if ();

  // one decode for the prescale and base frequency write strobes keeps reserved windows blocked for writes in one place
  function automatic logic reg_hit(input logic ok, input logic [9:0] addr, input logic [9:0] target);
    return ok && addr == target;
  endfunction : reg_hit

  assign cur_addr = rcp_pkg::full_addr(window_reg, i_addr);
  assign window_ok = window_reg <= rcp_pkg::WINDOW_SEL_MAX; // RULE_04
  // select stays reachable at the same offset of every window, so a reserved code can be left
  assign wr_window = i_wr_en && i_addr == rcp_pkg::WINDOW_SEL_OFS; // RULE_03
  assign wr_prescale = i_wr_en && reg_hit(window_ok, cur_addr, rcp_pkg::PRESCALE_ADDR); // RULE_01
  assign base_if.wr_hi = i_wr_en && reg_hit(window_ok, cur_addr, rcp_pkg::BASE_HI_ADDR); // RULE_07
  assign base_if.wr_lo = i_wr_en && reg_hit(window_ok, cur_addr, rcp_pkg::BASE_LO_ADDR); // RULE_07
  assign base_if.wdata = i_wdata;

  // base frequency: unsigned hertz, divisibility is the host's concern
  rcp_wide_reg #(
    .RESET_VALUE(rcp_pkg::BASE_HZ_RST)
  ) u_base_hz (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .bus(base_if)
  );

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      window_reg <= rcp_pkg::WINDOW_SEL_RST;
    end else if (wr_window) begin
      window_reg <= i_wdata; // RULE_03
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prescale_reg <= rcp_pkg::PRESCALE_RST[2:0];
    end else if (wr_prescale) begin
      prescale_reg <= i_wdata[2:0]; // RULE_01
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (i_addr == rcp_pkg::WINDOW_SEL_OFS) begin
      rdata_next = window_reg;
    end else if (window_ok) begin
      unique case (cur_addr)
        rcp_pkg::PRESCALE_ADDR: rdata_next = {5'h00, prescale_reg}; // RULE_01
        rcp_pkg::BASE_HI_ADDR: rdata_next = base_if.value[15:8]; // RULE_07
        rcp_pkg::BASE_LO_ADDR: rdata_next = base_if.value[7:0]; // RULE_07
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // read data holds until the next read, so a late host still finds it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= i_rd_en;
      if (i_rd_en) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rd_valid = rd_valid_reg;
  assign o_window_select = window_reg;
  assign o_prescale_en = prescale_reg;
  assign o_input0_base_hz = base_if.value; // RULE_05

  // divide by two on sampled edges; duty is exact only if ref is well below i_clk/2
  for (genvar g = 0; g < 3; g++) begin : g_prescale
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic half_reg;
    logic out_reg;
    logic rise;

    assign rise = sync2_reg && !prev_reg;

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        sync1_reg <= 1'b0;
        sync2_reg <= 1'b0;
        prev_reg <= 1'b0;
      end else begin
        sync1_reg <= i_ref_clk[g];
        sync2_reg <= sync1_reg;
        prev_reg <= sync2_reg;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        half_reg <= 1'b0;
      end else if (rise) begin
        half_reg <= !half_reg; // RULE_02
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        out_reg <= 1'b0;
      end else begin
        out_reg <= prescale_reg[g] ? half_reg : sync2_reg; // RULE_02
      end
    end

    assign o_ref_clk_out[g] = out_reg;

    pass_through_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_02
      !prescale_reg[g] |=> out_reg == $past(sync2_reg))
      else $error("undivided reference not passed through");

    halve_toggle_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_02
      rise |=> half_reg != $past(half_reg) ##1 !rise)
      else $error("halved reference did not toggle once per rising edge");

    halved_out_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_02
      prescale_reg[g] |=> out_reg == $past(half_reg))
      else $error("enabled reference not taken from the halving stage");
  end

  prescale_write_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_01
    wr_prescale |=> o_prescale_en == $past(i_wdata[2:0]))
    else $error("prescale enables not stored from bits two to zero");

  window_store_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_03
    wr_window |=> o_window_select == $past(i_wdata))
    else $error("window select not stored");

  reserved_block_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_04
    i_wr_en && window_reg > rcp_pkg::WINDOW_SEL_MAX && i_addr != rcp_pkg::WINDOW_SEL_OFS
    |=> $stable(o_prescale_en) && $stable(o_input0_base_hz))
    else $error("write reached registers through a reserved window");

  base_reset_a: assert property (@(posedge i_clk) // RULE_05
    $past(i_reset) |-> o_input0_base_hz == rcp_pkg::BASE_HZ_RST)
    else $error("base frequency not at 40 kHz after reset");

  byte_order_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_07
    i_rd_en && window_ok && cur_addr == rcp_pkg::BASE_HI_ADDR && i_addr != rcp_pkg::WINDOW_SEL_OFS
    |=> o_rd_valid && o_rdata == $past(o_input0_base_hz[15:8]))
    else $error("upper byte not returned at lower address");

  low_byte_read_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_07
    i_rd_en && reg_hit(window_ok, cur_addr, rcp_pkg::BASE_LO_ADDR)
    |=> o_rd_valid && o_rdata == $past(o_input0_base_hz[7:0]))
    else $error("lower byte not returned at higher address");

  prescale_read_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_01
    i_rd_en && reg_hit(window_ok, cur_addr, rcp_pkg::PRESCALE_ADDR)
    |=> o_rd_valid && o_rdata == {5'h00, $past(o_prescale_en)})
    else $error("prescale enables not read back in bits two to zero");

  window_read_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_03
    i_rd_en && i_addr == rcp_pkg::WINDOW_SEL_OFS |=> o_rd_valid && o_rdata == $past(o_window_select))
    else $error("window select not read back");

  reserved_read_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_04
    i_rd_en && !window_ok && i_addr != rcp_pkg::WINDOW_SEL_OFS |=> o_rd_valid && o_rdata == 8'h00)
    else $error("read through a reserved window returned data");

  read_pulse_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_03
    o_rd_valid == ($past(i_rd_en) && !$past(i_reset)))
    else $error("read valid not a single cycle after the read strobe");

  window_reset_a: assert property (@(posedge i_clk) // RULE_03
    $past(i_reset) |-> o_window_select == rcp_pkg::WINDOW_SEL_RST && !o_rd_valid)
    else $error("window select not cleared by reset");

  prescale_reset_a: assert property (@(posedge i_clk) // RULE_01
    $past(i_reset) |-> o_prescale_en == rcp_pkg::PRESCALE_RST[2:0])
    else $error("prescale enables not cleared by reset");

  ref_reset_a: assert property (@(posedge i_clk) // RULE_02
    $past(i_reset) |-> o_ref_clk_out == 3'h0)
    else $error("reference outputs not low after reset");
endmodule : rcp_bank

// File: verilog/rcp_wide_reg.sv
/*
  16-bit register written as two bytes, most significant byte first.
  assumes strobes from the bank on the same clock, one byte per cycle.
*/
`timescale 1ns/1ps
module rcp_wide_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input wire logic i_clk,
  input wire logic i_reset,
  rcp_byte_if.store bus
);
  logic [7:0] staged_hi_reg;
  logic [15:0] value_reg;

  // upper byte waits here so consumers never see a half-written value
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      staged_hi_reg <= RESET_VALUE[15:8];
    end else if (bus.wr_hi) begin
      staged_hi_reg <= bus.wdata; // RULE_09
    end
  end

  // a low-byte write alone reuses the last staged upper byte
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      value_reg <= RESET_VALUE;
    end else if (bus.wr_lo) begin
      value_reg <= {staged_hi_reg, bus.wdata}; // RULE_09
    end
  end

  assign bus.value = value_reg;

  commit_low_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_09
    bus.wr_lo |=> value_reg == {$past(staged_hi_reg), $past(bus.wdata)})
    else $error("low byte write did not commit staged value");

  hold_value_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_09
    !bus.wr_lo |=> $stable(value_reg))
    else $error("active value changed without a low byte write");

  stage_high_a: assert property (@(posedge i_clk) disable iff (i_reset) // RULE_07
    bus.wr_hi ##1 bus.wr_lo |=> value_reg[15:8] == $past(bus.wdata, 2))
    else $error("upper byte not placed in upper half");
endmodule : rcp_wide_reg
